// >>> core/mcuexe_core.sv
// instruction execution core with avalon register slave
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module mcuexe_core (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic [2:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  output logic      [mcuexe_pkg::PC_W-1:0] pm_addr,
  input  wire logic [15:0]                 pm_data,
  output logic      [7:0]                  dm_addr,
  input  wire logic [7:0]                  dm_rdata,
  output logic      [7:0]                  dm_wdata,
  output logic                             dm_we,
  input  wire logic                        wdt_timeout,
  output logic                             wdt_clear
);
  import mcuexe_pkg::*;

  mcuexe_phase_t   ph_q;
  mcuexe_pair_t    pair_q;
  logic            dummy_q, run_q, halt_q, emi_q;
  logic            c_q, ac_q, z_q, ov_q, pdf_q, to_q;
  logic [15:0]     ir_q, tab_q;
  logic [7:0]      op_q, acc_q, tblp_q, table_high_latch_q;
  logic [PC_W-1:0] pc_q, pm_addr_q;
  logic [PC_W-1:0] stk_q [0:STK_N-1];
  logic [SP_W-1:0] sp_q, sp_top;
  logic [7:0]      dm_addr_q, dm_wdata_q;
  logic            dm_we_q, wdt_clear_q, wait_q;
  logic [31:0]     rdata_q, rd_mux;

  logic            running, exec, tab_exec, tab_pend, bus_wr;
  logic [4:0]      opc;
  logic [2:0]      sub;
  logic [7:0]      imm, mask, res;
  logic [10:0]     sum;
  logic            wr_mem, wr_acc, upd_arith, upd_z, skip, jump, ret, two, pcl_wr;
  logic            is_interrupt_return_op, is_call, is_wdt, is_wdt1, is_wdt2, is_halt, wd_clr;

  // result {ov, ac, c, sum}
  function automatic logic [10:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic ci);
    logic [8:0] s;
    logic [4:0] l;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {(a[7] == b[7]) && (s[7] != a[7]), l[4], s[8], s[7:0]};
  endfunction

  function automatic logic is_op(input logic [4:0] o, input logic [4:0] a,
                                 input logic [4:0] b);
    return (o == a) || (o == b);
  endfunction

  assign running  = run_q & ~halt_q;
  assign exec     = running && ph_q == PH_EXEC && !dummy_q;
  assign tab_pend = dummy_q && is_op(ir_q[OP_HI:OP_LO], OP_TABC, OP_TABL);
  assign tab_exec = running && ph_q == PH_EXEC && tab_pend;
  assign bus_wr   = avs_write & ~wait_q;
  assign sp_top   = sp_q - 3'h1;

  always_comb begin
    opc       = ir_q[OP_HI:OP_LO];
    sub       = ir_q[SUB_HI:0];
    imm       = ir_q[7:0];
    mask      = 8'h01 << ir_q[BIT_HI:BIT_LO];
    sum       = alu_add(acc_q, (opc == OP_ADD_X) ? imm : op_q,
                        is_op(opc, OP_ADC_A, OP_ADC_M) & c_q);
    res       = op_q;
    wr_mem    = 1'b0;
    wr_acc    = 1'b0;
    upd_arith = 1'b0;
    upd_z     = 1'b0;
    skip      = 1'b0;
    jump      = 1'b0;
    ret       = 1'b0;
    two       = 1'b0;
    case (opc)
      OP_ADD_A, OP_ADD_X, OP_ADC_A: begin
        res = sum[7:0]; wr_acc = 1'b1; upd_arith = 1'b1;
      end
      OP_ADD_M, OP_ADC_M: begin
        res = sum[7:0]; wr_mem = 1'b1; upd_arith = 1'b1;
      end
      OP_AND_A: begin res = acc_q & op_q; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_AND_X: begin res = acc_q & imm; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_AND_M: begin res = acc_q & op_q; wr_mem = 1'b1; upd_z = 1'b1; end
      OP_CPL:   begin res = ~op_q; wr_mem = 1'b1; upd_z = 1'b1; end
      OP_COMPLEMENT_TO_ACC_OP:  begin res = ~op_q; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_CLR:   begin res = 8'h00; wr_mem = 1'b1; end
      OP_CLRB:  begin res = op_q & ~mask; wr_mem = 1'b1; end
      OP_SETB:  begin res = op_q | mask; wr_mem = 1'b1; end
      OP_SZ:    skip = (op_q == 8'h00);
      OP_SZA:   begin wr_acc = 1'b1; skip = (op_q == 8'h00); end
      OP_SZB:   skip = ~|(op_q & mask);
      OP_SNZB:  skip = |(op_q & mask);
      OP_SIZ, OP_INC_SKIP_ZERO_ACC_OP: begin
        res = op_q + 8'h01; skip = (res == 8'h00);
        wr_mem = (opc == OP_SIZ); wr_acc = (opc == OP_INC_SKIP_ZERO_ACC_OP);
      end
      OP_SDZ, OP_DEC_SKIP_ZERO_ACC_OP: begin
        res = op_q - 8'h01; skip = (res == 8'h00);
        wr_mem = (opc == OP_SDZ); wr_acc = (opc == OP_DEC_SKIP_ZERO_ACC_OP);
      end
      OP_SWAP:  begin res = {op_q[3:0], op_q[7:4]}; wr_mem = 1'b1; end
      OP_NIBBLE_SWAP_TO_ACC_OP: begin res = {op_q[3:0], op_q[7:4]}; wr_acc = 1'b1; end
      OP_JMP, OP_CALL: begin jump = 1'b1; two = 1'b1; end
      OP_RETX:  begin res = imm; wr_acc = 1'b1; ret = 1'b1; two = 1'b1; end
      OP_TABC, OP_TABL: two = 1'b1;
      OP_MISC:  begin
        ret = (sub == SUB_RET) || (sub == SUB_INTERRUPT_RETURN_OP);
        two = ret;
      end
      default: ;
    endcase
    pcl_wr  = wr_mem && dm_addr_q == PCL_ADDR;
    two     = two | skip | pcl_wr;
    is_call = opc == OP_CALL;
    is_interrupt_return_op = opc == OP_MISC && sub == SUB_INTERRUPT_RETURN_OP;
    is_wdt  = opc == OP_MISC && sub == SUB_WDT;
    is_wdt1 = opc == OP_MISC && sub == SUB_WDT1;
    is_wdt2 = opc == OP_MISC && sub == SUB_WDT2;
    is_halt = opc == OP_MISC && sub == SUB_HALT;
    wd_clr  = exec && (is_wdt || (is_wdt1 && pair_q == PAIR_SECOND) ||
                       (is_wdt2 && pair_q == PAIR_FIRST));
  end

  // four clocks make one instruction cycle; exec is the one-cycle enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_q <= PH_FETCH;
    end else if (running) begin
      case (ph_q)
        PH_FETCH:  ph_q <= PH_DECODE;
        PH_DECODE: ph_q <= PH_READ;
        PH_READ:   ph_q <= PH_EXEC;
        default:   ph_q <= PH_FETCH;
      endcase
    end
  end

  // the dummy cycle refills the fetch after a change of flow
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dummy_q <= 1'b0;
    end else if (running && ph_q == PH_EXEC) begin
      dummy_q <= exec & two;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pm_addr_q <= '0;
      ir_q      <= 16'h0000;
      tab_q     <= 16'h0000;
      dm_addr_q <= 8'h00;
      op_q      <= 8'h00;
    end else if (running) begin
      if (ph_q == PH_FETCH) begin
        pm_addr_q <= !tab_pend ? pc_q :
                     {(ir_q[OP_HI:OP_LO] == OP_TABL) ? LAST_PAGE : pc_q[PC_W-1:PG_LO],
                      tblp_q};
      end
      if (ph_q == PH_DECODE && !dummy_q) begin
        ir_q      <= pm_data;
        dm_addr_q <= pm_data[7:0];
      end
      if (ph_q == PH_DECODE && tab_pend) begin
        tab_q <= pm_data;
      end
      if (ph_q == PH_READ) begin
        op_q <= (dm_addr_q == PCL_ADDR) ? pc_q[7:0] : dm_rdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_q <= '0;
      sp_q <= '0;
    end else if (exec) begin
      if (jump) begin
        pc_q <= ir_q[PC_W-1:0];
      end else if (ret) begin
        pc_q <= stk_q[sp_top];
      end else if (pcl_wr) begin
        pc_q <= {pc_q[PC_W-1:PG_LO], res};
      end else if (skip) begin
        pc_q <= pc_q + 11'h002;
      end else begin
        pc_q <= pc_q + 11'h001;
      end
      if (is_call) begin
        sp_q <= sp_q + 3'h1;
      end else if (ret) begin
        sp_q <= sp_top;
      end
    end
  end

  // stack wraps silently on overflow, as a fixed-depth ring
  always_ff @(posedge sys_clk) begin
    if (exec && is_call) begin
      stk_q[sp_q] <= pc_q + 11'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q <= 8'h00;
    end else if (exec && wr_acc) begin
      acc_q <= res;
    end else if (bus_wr && avs_address == RG_ACC) begin
      acc_q <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {ov_q, ac_q, c_q, z_q} <= 4'h0;
    end else if (exec && upd_arith) begin
      {ov_q, ac_q, c_q} <= sum[10:8];
      z_q               <= (res == 8'h00);
    end else if (exec && upd_z) begin
      z_q <= (res == 8'h00);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dm_we_q    <= 1'b0;
      dm_wdata_q <= 8'h00;
      table_high_latch_q     <= 8'h00;
    end else begin
      dm_we_q <= (exec && wr_mem && !pcl_wr) || tab_exec;
      if (tab_exec) begin
        dm_wdata_q <= tab_q[7:0];
        table_high_latch_q     <= tab_q[15:8];
      end else if (exec) begin
        dm_wdata_q <= res;
      end
    end
  end

  // a lone repeated half never completes the pair
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pair_q <= PAIR_NONE;
    end else if (exec) begin
      if (is_wdt1 && pair_q != PAIR_SECOND) begin
        pair_q <= PAIR_FIRST;
      end else if (is_wdt2 && pair_q != PAIR_FIRST) begin
        pair_q <= PAIR_SECOND;
      end else begin
        pair_q <= PAIR_NONE;
      end
    end
  end

  // a timeout arriving with a clear still sets the flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      to_q        <= 1'b0;
      pdf_q       <= 1'b0;
      halt_q      <= 1'b0;
      wdt_clear_q <= 1'b0;
    end else begin
      wdt_clear_q <= wd_clr | (exec & is_halt);
      to_q        <= wdt_timeout | (to_q & ~wd_clr & ~(exec & is_halt));
      pdf_q       <= (exec & is_halt) | (pdf_q & ~wd_clr);
      halt_q      <= (exec & is_halt) |
                     (halt_q & ~(bus_wr && avs_address == RG_CTRL &&
                                 avs_writedata[CT_WAKE]));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_q  <= 1'b0;
      emi_q  <= 1'b0;
      tblp_q <= 8'h00;
    end else begin
      if (exec && is_interrupt_return_op) begin
        emi_q <= 1'b1;
      end else if (bus_wr && avs_address == RG_CTRL) begin
        emi_q <= avs_writedata[CT_EMI];
      end
      if (bus_wr && avs_address == RG_CTRL) begin
        run_q <= avs_writedata[CT_RUN];
      end
      if (bus_wr && avs_address == RG_TBLP) begin
        tblp_q <= avs_writedata[7:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      RG_CTRL: begin
        rd_mux[CT_RUN] = run_q;
        rd_mux[CT_EMI] = emi_q;
      end
      RG_STAT: begin
        rd_mux[ST_C]    = c_q;
        rd_mux[ST_AC]   = ac_q;
        rd_mux[ST_Z]    = z_q;
        rd_mux[ST_OV]   = ov_q;
        rd_mux[ST_PDF]  = pdf_q;
        rd_mux[ST_TO]   = to_q;
        rd_mux[ST_EMI]  = emi_q;
        rd_mux[ST_HALT] = halt_q;
      end
      RG_ACC:  rd_mux[7:0] = acc_q;
      RG_PC:   rd_mux[PC_W-1:0] = pc_q;
      RG_TBLP: rd_mux[7:0] = tblp_q;
      RG_TABLE_HIGH_LATCH: rd_mux[7:0] = table_high_latch_q;
      default: ;
    endcase
  end

  // one wait state per access keeps read data registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign pm_addr         = pm_addr_q;
  assign dm_addr         = dm_addr_q;
  assign dm_wdata        = dm_wdata_q;
  assign dm_we           = dm_we_q;
  assign wdt_clear       = wdt_clear_q;

  a_skip_two: assert property (@(posedge sys_clk) disable iff (rst)
    exec && skip && !pcl_wr |=> dummy_q && pc_q == $past(pc_q) + 11'h002)
    else $error("skip did not take two cycles");
  a_noskip_one: assert property (@(posedge sys_clk) disable iff (rst)
    exec && !two |=> !dummy_q)
    else $error("plain instruction took an extra cycle");
  a_pcl_two: assert property (@(posedge sys_clk) disable iff (rst)
    exec && pcl_wr |=> dummy_q && !dm_we_q && pc_q[7:0] == $past(res))
    else $error("pc low write not two cycles");
  a_pair_half: assert property (@(posedge sys_clk) disable iff (rst)
    exec && is_wdt1 && pair_q != PAIR_SECOND && !wdt_timeout
    |=> to_q == $past(to_q) && pdf_q == $past(pdf_q) && !wdt_clear_q)
    else $error("lone watchdog half had an effect");
  a_pair_done: assert property (@(posedge sys_clk) disable iff (rst)
    exec && is_wdt2 && pair_q == PAIR_FIRST && !wdt_timeout
    |=> !to_q && !pdf_q && wdt_clear_q)
    else $error("completed pair did not clear flags");
  a_single_clr: assert property (@(posedge sys_clk) disable iff (rst)
    exec && is_wdt && !wdt_timeout |=> !to_q && !pdf_q && wdt_clear_q ##1 !wdt_clear_q)
    else $error("single watchdog clear failed");
  a_arith_flags: assert property (@(posedge sys_clk) disable iff (rst)
    exec && upd_arith |=> c_q == $past(sum[8]) && ov_q == $past(sum[10])
                          && z_q == ($past(res) == 8'h00))
    else $error("add flags wrong");
  a_and_zero: assert property (@(posedge sys_clk) disable iff (rst)
    exec && opc == OP_AND_X |=> acc_q == ($past(acc_q) & $past(imm))
                                && c_q == $past(c_q) && z_q == (acc_q == 8'h00))
    else $error("and result or flags wrong");
  a_call_push: assert property (@(posedge sys_clk) disable iff (rst)
    exec && is_call |=> sp_q == $past(sp_q) + 3'h1 && dummy_q
                        && stk_q[$past(sp_q)] == $past(pc_q) + 11'h001)
    else $error("call push wrong");
  a_halt_stop: assert property (@(posedge sys_clk) disable iff (rst)
    exec && is_halt && !wdt_timeout |=> halt_q && pdf_q && !to_q && wdt_clear_q
                                        ##1 ph_q == PH_FETCH)
    else $error("power-down entry wrong");
  a_interrupt_return_op_emi: assert property (@(posedge sys_clk) disable iff (rst)
    exec && is_interrupt_return_op |=> emi_q && sp_q == $past(sp_top))
    else $error("interrupt return wrong");
endmodule
`default_nettype wire

// >>> core/mcuexe_pkg.sv
// constants and types of the instruction execution block
package mcuexe_pkg;
  localparam int PC_W  = 11;
  localparam int SP_W  = 3;
  localparam int STK_N = 8;
  // instruction word fields
  localparam int OP_HI  = 15;
  localparam int OP_LO  = 11;
  localparam int BIT_HI = 10;
  localparam int BIT_LO = 8;
  localparam int SUB_HI = 2;
  localparam int PG_LO  = 8;
  // opcodes
  localparam logic [4:0] OP_MISC   = 5'h00;
  localparam logic [4:0] OP_ADD_A  = 5'h01;
  localparam logic [4:0] OP_ADD_M  = 5'h02;
  localparam logic [4:0] OP_ADD_X  = 5'h03;
  localparam logic [4:0] OP_ADC_A  = 5'h04;
  localparam logic [4:0] OP_ADC_M  = 5'h05;
  localparam logic [4:0] OP_AND_A  = 5'h06;
  localparam logic [4:0] OP_AND_M  = 5'h07;
  localparam logic [4:0] OP_AND_X  = 5'h08;
  localparam logic [4:0] OP_CPL    = 5'h09;
  localparam logic [4:0] OP_COMPLEMENT_TO_ACC_OP   = 5'h0a;
  localparam logic [4:0] OP_CLR    = 5'h0b;
  localparam logic [4:0] OP_CLRB   = 5'h0c;
  localparam logic [4:0] OP_SETB   = 5'h0d;
  localparam logic [4:0] OP_SZ     = 5'h0e;
  localparam logic [4:0] OP_SZA    = 5'h0f;
  localparam logic [4:0] OP_SZB    = 5'h10;
  localparam logic [4:0] OP_SNZB   = 5'h11;
  localparam logic [4:0] OP_SIZ    = 5'h12;
  localparam logic [4:0] OP_SDZ    = 5'h13;
  localparam logic [4:0] OP_INC_SKIP_ZERO_ACC_OP   = 5'h14;
  localparam logic [4:0] OP_DEC_SKIP_ZERO_ACC_OP   = 5'h15;
  localparam logic [4:0] OP_JMP    = 5'h16;
  localparam logic [4:0] OP_CALL   = 5'h17;
  localparam logic [4:0] OP_RETX   = 5'h18;
  localparam logic [4:0] OP_TABC   = 5'h19;
  localparam logic [4:0] OP_TABL   = 5'h1a;
  localparam logic [4:0] OP_SWAP   = 5'h1b;
  localparam logic [4:0] OP_NIBBLE_SWAP_TO_ACC_OP  = 5'h1c;
  // sub codes of OP_MISC in the low bits
  localparam logic [2:0] SUB_NOP   = 3'h0;
  localparam logic [2:0] SUB_RET   = 3'h1;
  localparam logic [2:0] SUB_INTERRUPT_RETURN_OP  = 3'h2;
  localparam logic [2:0] SUB_WDT   = 3'h3;
  localparam logic [2:0] SUB_WDT1  = 3'h4;
  localparam logic [2:0] SUB_WDT2  = 3'h5;
  localparam logic [2:0] SUB_HALT  = 3'h6;
  localparam logic [7:0] PCL_ADDR  = 8'h07;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  // register word indices and bit positions
  localparam logic [2:0] RG_CTRL = 3'h0;
  localparam logic [2:0] RG_STAT = 3'h1;
  localparam logic [2:0] RG_ACC  = 3'h2;
  localparam logic [2:0] RG_PC   = 3'h3;
  localparam logic [2:0] RG_TBLP = 3'h4;
  localparam logic [2:0] RG_TABLE_HIGH_LATCH = 3'h5;
  localparam int CT_RUN = 0;
  localparam int CT_WAKE = 1;
  localparam int CT_EMI = 2;
  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO = 5;
  localparam int ST_EMI = 6;
  localparam int ST_HALT = 7;
  typedef enum logic [3:0] {
    PH_FETCH  = 4'b0001,
    PH_DECODE = 4'b0010,
    PH_READ   = 4'b0100,
    PH_EXEC   = 4'b1000
  } mcuexe_phase_t;
  typedef enum logic [2:0] {
    PAIR_NONE   = 3'b001,
    PAIR_FIRST  = 3'b010,
    PAIR_SECOND = 3'b100
  } mcuexe_pair_t;
endpackage

// >>> verif/mcuexe_mem_model.sv
// behavioural program and data memories facing the execution core
`timescale 1ns/1ns
`default_nettype none
module mcuexe_mem_model (
  input  wire logic                        sys_clk,
  input  wire logic [mcuexe_pkg::PC_W-1:0] pm_addr,
  output logic      [15:0]                 pm_data,
  input  wire logic [7:0]                  dm_addr,
  output logic      [7:0]                  dm_rdata,
  input  wire logic [7:0]                  dm_wdata,
  input  wire logic                        dm_we
);
  import mcuexe_pkg::*;
  logic [15:0] pm [0:(1<<PC_W)-1];
  logic [7:0]  dm [0:255];
  // combinational reads, so the core sees the word one edge after the address moves
  assign pm_data  = pm[pm_addr];
  assign dm_rdata = dm[dm_addr];
  // bench preloads both arrays only while the core is stopped
  always @(posedge sys_clk) begin
    if (dm_we === 1'b1) begin
      dm[dm_addr] <= dm_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the instruction execution core
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mcuexe_pkg::*;
  logic            sys_clk;
  logic            rst;
  logic [2:0]      avs_address;
  logic            avs_read;
  logic            avs_write;
  logic [31:0]     avs_writedata;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic [PC_W-1:0] pm_addr;
  logic [15:0]     pm_data;
  logic [7:0]      dm_addr;
  logic [7:0]      dm_rdata;
  logic [7:0]      dm_wdata;
  logic            dm_we;
  logic            wdt_timeout;
  logic            wdt_clear;
  int              n_errors = 0;
  int              num_checks = 0;
  int              cyc = 0;
  int              wr_t[$];
  logic [15:0]     wr_ad[$];
  int              clr_t[$];
  logic [15:0]     prog [0:70];
  logic [31:0]     rd;
  int              ev_c [0:13] = '{1, 3, 6, 8, 9, 11, 12, 14, 19, 23, 25, 27, 30, 44};
  logic [15:0]     ev_ad [0:13] = '{16'h2040, 16'h2100, 16'h2208, 16'h2385, 16'h2400,
    16'h2621, 16'h2700, 16'h2804, 16'h2900, 16'h2c00, 16'h2f30, 16'h2e77, 16'h2d01, 16'h2d03};
  logic [15:0]     dmi [0:11] = '{16'h203f, 16'h23a5, 16'h24ff, 16'h255a, 16'h2612, 16'h27ff,
    16'h2805, 16'h295b, 16'h2a80, 16'h2b00, 16'h2c3c, 16'h3101};

  mcuexe_core dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .pm_addr, .pm_data, .dm_addr, .dm_rdata, .dm_wdata,
    .dm_we, .wdt_timeout, .wdt_clear);
  mcuexe_mem_model mem (.sys_clk, .pm_addr, .pm_data, .dm_addr, .dm_rdata, .dm_wdata, .dm_we);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // log every memory write and watchdog clear with its clock count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rst === 1'b0 && dm_we === 1'b1) begin
      wr_t.push_back(cyc);
      wr_ad.push_back({dm_addr, dm_wdata});
    end
    if (rst === 1'b0 && wdt_clear === 1'b1) begin
      clr_t.push_back(cyc);
    end
  end

  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) n_errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic pulse_timeout;
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial begin
    #100000;
    n_errors++;
    finish_test;
  end

  initial begin
    rst           = 1'b1;
    avs_address   = 3'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    wdt_timeout   = 1'b0;
    prog = '{
      0: {OP_ADD_X, 3'h0, 8'h70}, 1: {OP_ADC_M, 3'h0, 8'h20}, 2: {OP_AND_X, 3'h0, 8'h0f},
      3: {OP_CLR, 3'h0, 8'h21}, 4: {OP_SZ, 3'h0, 8'h21}, 5: {OP_CLR, 3'h0, 8'h30},
      6: {OP_SETB, 3'h3, 8'h22}, 7: {OP_SZ, 3'h0, 8'h22}, 8: {OP_CLRB, 3'h5, 8'h23},
      9: {OP_CPL, 3'h0, 8'h24}, 10: {OP_COMPLEMENT_TO_ACC_OP, 3'h0, 8'h25}, 11: {OP_SWAP, 3'h0, 8'h26},
      12: {OP_SIZ, 3'h0, 8'h27}, 13: {OP_CLR, 3'h0, 8'h30}, 14: {OP_SDZ, 3'h0, 8'h28},
      15: {OP_SNZB, 3'h2, 8'h28}, 16: {OP_CLR, 3'h0, 8'h30}, 17: {OP_SZB, 3'h0, 8'h28},
      18: {OP_CLR, 3'h0, 8'h30}, 19: {OP_ADD_M, 3'h0, 8'h29}, 20: {OP_ADD_A, 3'h0, 8'h2a},
      21: {OP_SZA, 3'h0, 8'h2b}, 22: {OP_CLR, 3'h0, 8'h30}, 23: {OP_AND_M, 3'h0, 8'h2c},
      24: {OP_TABC, 3'h0, 8'h2f}, 25: {OP_TABL, 3'h0, 8'h2e}, 26: {OP_CALL, 11'h028},
      27: {OP_NIBBLE_SWAP_TO_ACC_OP, 3'h0, 8'h26}, 28: {OP_MISC, 8'h00, SUB_WDT1},
      29: {OP_MISC, 8'h00, SUB_WDT1}, 30: {OP_MISC, 8'h00, SUB_WDT2},
      32: {OP_MISC, 8'h00, SUB_WDT2}, 33: {OP_MISC, 8'h00, SUB_WDT},
      34: {OP_SETB, 3'h4, 8'h07}, 40: {OP_SETB, 3'h0, 8'h2d}, 41: {OP_MISC, 8'h00, SUB_INTERRUPT_RETURN_OP},
      50: {OP_JMP, 11'h03c}, 60: {OP_SETB, 3'h1, 8'h2d}, 61: {OP_MISC, 8'h00, SUB_HALT},
      62: {OP_MISC, 8'h00, SUB_WDT1}, 63: {OP_MISC, 8'h00, SUB_WDT1},
      65: {OP_MISC, 8'h00, SUB_WDT2}, 66: {OP_SZ, 3'h0, 8'h31}, 67: {OP_JMP, 11'h042},
      68: {OP_MISC, 8'h00, SUB_WDT1}, 69: {OP_MISC, 8'h00, SUB_WDT2},
      70: {OP_JMP, 11'h046}, default: 16'h0000};
    for (int i = 0; i < (1 << PC_W); i++) mem.pm[i] = (i <= 70) ? prog[i] : 16'h0000;
    mem.pm[11'h705] = 16'hbe77;
    for (int i = 0; i < 256; i++) mem.dm[i] = 8'h00;
    for (int i = 0; i < 12; i++) mem.dm[dmi[i][15:8]] = dmi[i][7:0];
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    av(1'b1, RG_ACC, 32'h90);
    av(1'b1, RG_TBLP, 32'h05);
    pulse_timeout();
    av(1'b1, RG_CTRL, 32'h1);
    for (int i = 0; i < 100; i++) begin
      av(1'b0, RG_STAT, 32'h0);
      if (rd[ST_HALT] === 1'b1) break;
    end
    check(rd, 32'hdd);
    av(1'b0, RG_ACC, 32'h0);
    check(rd, 32'h12);
    av(1'b0, RG_TABLE_HIGH_LATCH, 32'h0);
    check(rd, 32'hbe);
    // status is read-only and unmapped words read zero
    av(1'b1, RG_STAT, 32'h0);
    av(1'b0, RG_STAT, 32'h0);
    check(rd, 32'hdd);
    av(1'b1, 3'h7, 32'hff);
    av(1'b0, 3'h7, 32'h0);
    check(rd, 32'h0);
    check(wr_ad.size(), 14);
    for (int i = 0; i < wr_ad.size() && i < 14; i++) begin
      check(wr_ad[i], ev_ad[i]);
      check(wr_t[i] - wr_t[0], 4 * (ev_c[i] - 1));
    end
    check(clr_t.size(), 3);
    if (clr_t.size() == 3) begin
      check(clr_t[1] - clr_t[0], 12);
      check(clr_t[2] - clr_t[1], 24);
    end
    // lone and broken halves must leave both flags set
    clr_t.delete();
    pulse_timeout();
    av(1'b1, RG_CTRL, 32'h7);
    repeat (100) @(posedge sys_clk);
    av(1'b1, RG_CTRL, 32'h4);
    av(1'b0, RG_STAT, 32'h0);
    check(rd, 32'h7d);
    check(clr_t.size(), 0);
    mem.dm[8'h31] = 8'h00;
    av(1'b1, RG_CTRL, 32'h5);
    repeat (100) @(posedge sys_clk);
    av(1'b1, RG_CTRL, 32'h4);
    av(1'b0, RG_STAT, 32'h0);
    check(rd, 32'h4d);
    check(clr_t.size(), 1);
    finish_test();
  end
endmodule
`default_nettype wire
